// ==== mlsg_load.sv ====
`timescale 1ns/1ps
module mlsg_load
    import mlsg_pkg::*;
(
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic [CUR_W-1:0] demand,
    input wire logic             run_req,
    input wire logic             relief,
    output logic     [CUR_W-1:0] motor_current,
    output logic                 motor_run
);
    // Process halves its feed while relief is asked, as a real feeder would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_current <= '0;
            motor_run     <= 1'b0;
        end else begin
            motor_current <= relief ? demand >> 1 : demand;
            motor_run     <= run_req;
        end
    end
endmodule

// ==== mlsg_pkg.sv ====
package mlsg_pkg;
    localparam int CUR_W        = 16;
    localparam int TMR_W        = 24;
    localparam int NUM_STALL    = 2;
    localparam int ADDR_W       = 12;

    // Register byte addresses
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_SHED_PICK = 12'h004;
    localparam logic [11:0] OFS_SHED_DROP = 12'h008;
    localparam logic [11:0] OFS_SHED_TPU  = 12'h00C;
    localparam logic [11:0] OFS_SHED_TDO  = 12'h010;
    localparam logic [11:0] OFS_START_DLY = 12'h014;
    localparam logic [11:0] OFS_RUN_DLY   = 12'h018;
    localparam logic [11:0] OFS_STATUS    = 12'h01C;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h020;
    localparam logic [11:0] OFS_IRQ_MASK  = 12'h024;
    localparam logic [11:0] OFS_STALL0    = 12'h040;
    localparam logic [11:0] STALL_STRIDE  = 12'h010;
    localparam logic [11:0] OFS_ST_PICK   = 12'h000;
    localparam logic [11:0] OFS_ST_TMR    = 12'h004;
    localparam logic [11:0] OFS_ST_MODE   = 12'h008;

    // Control fields
    localparam int CTRL_SHED_EN  = 0;
    localparam int CTRL_SHED_POL = 1;
    // Status / irq fields
    localparam int ST_SHED      = 0;
    localparam int ST_ALARM0    = 1;
    localparam int ST_TRIP0     = 3;
    localparam int IRQ_W        = 5;

    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage

// ==== mlsg_props.sv ====
`timescale 1ns/1ps
module mlsg_props
    import mlsg_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [CUR_W-1:0]     motor_current,
    input wire logic                 motor_run,
    input wire logic                 shed_contact,
    input wire logic [NUM_STALL-1:0] stall_alarm,
    input wire logic [NUM_STALL-1:0] stall_trip
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_setup_gets_ready:
        assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_in_access:
        assert property (pready |-> psel && penable) else $error("ready outside access");
    a_ready_one_cycle:
        assert property (pready |=> !pready) else $error("ready held too long");
    a_error_with_ready:
        assert property (pslverr |-> pready) else $error("slave error without ready");
    a_idle_no_ready:
        assert property (!psel |=> !pready) else $error("ready while idle");
    a_shed_frozen_stopped:
        assert property ((!motor_run && !psel) [*4] |=> $stable(shed_contact))
            else $error("contact moved while stopped");
    a_stall_idle_stopped:
        assert property (!motor_run [*4] |-> stall_alarm == '0 && stall_trip == '0)
            else $error("stall out while stopped");
    a_zero_no_alarm:
        assert property ((motor_current == '0) [*4] |-> stall_alarm == '0) else $error("alarm with no current");
    a_trip_after_alarm:
        assert property ($rose(stall_trip[0]) |-> stall_alarm[0]) else $error("trip without alarm");
endmodule
////////////////////////////////////////
bind mlsg_top mlsg_props i_mlsg_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .motor_current(motor_current), .motor_run(motor_run),
    .shed_contact(shed_contact), .stall_alarm(stall_alarm), .stall_trip(stall_trip));

// ==== mlsg_stall.sv ====
`timescale 1ns/1ps
module mlsg_stall
    import mlsg_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             enable,
    input  wire logic [CUR_W-1:0] current,
    input  wire logic [CUR_W-1:0] pickup,
    input  wire logic [TMR_W-1:0] run_delay,
    input  wire logic [TMR_W-1:0] trip_delay,
    input  wire logic             trip_active,
    output logic                  alarm,
    output logic                  trip
);
    logic over;
    logic run_ok;
    logic trip_ok;

    // Only while running and past start delay
    assign over = enable && (current > pickup);

    // Short excursions are filtered by the run delay
    mlsg_timer #(.W(TMR_W)) u_run (
        .pclk    (pclk),
        .presetn (presetn),
        .cond    (over),
        .limit   (run_delay),
        .expired (run_ok)
    );

    mlsg_timer #(.W(TMR_W)) u_trip (
        .pclk    (pclk),
        .presetn (presetn),
        .cond    (over),
        .limit   (trip_delay),
        .expired (trip_ok)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm <= 1'b0;
            trip  <= 1'b0;
        end else begin
            alarm <= run_ok && over;
            // Blocked mode still gives the alarm path above
            trip  <= trip_active && trip_ok && run_ok && over;
        end
    end
endmodule

// ==== mlsg_tb_top.sv ====
`timescale 1ns/1ps
module mlsg_tb_top;
    import mlsg_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [CUR_W-1:0]  motor_current, demand;
    logic              motor_run, run_req, shed_contact, irq, er, pol, s0;
    logic [1:0]        stall_alarm, stall_trip;
    int                errors, check_count, seed, cyc, n, tdo;
    logic [15:0]       hi;
    mlsg_top i_mlsg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .motor_current(motor_current), .motor_run(motor_run), .shed_contact(shed_contact),
        .stall_alarm(stall_alarm), .stall_trip(stall_trip), .irq(irq));
    mlsg_load i_mlsg_load (.pclk(pclk), .presetn(presetn), .demand(demand), .run_req(run_req),
        .relief(shed_contact ^ pol), .motor_current(motor_current), .motor_run(motor_run));
    ////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Entered just after an edge; the extra idle edge keeps strobes single-driven
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task meas(input logic v);
        n = 0;
        while (shed_contact !== v && n < 300) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task wait_alarm;
        n = 0;
        while (stall_alarm[0] !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        seed = 25;
        {presetn, psel, penable, pwrite, paddr, pwdata, demand, run_req, pol} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, OFS_CTRL, 0); chk(rd, 0);
        apb(0, OFS_SHED_TPU, 0); chk(rd, 0);
        apb(0, OFS_SHED_PICK, 0); chk(rd, 32'h0000FFFF);
        apb(0, 12'h030, 0); chk(er, 1);
        tdo = $random(seed);
        apb(1, OFS_SHED_DROP, tdo);
        apb(0, OFS_SHED_DROP, 0);
        chk(rd, tdo & 32'hFFFF);
        $display("register test done");
        // Pickup kept at or below the stall pickups set later
        apb(1, OFS_SHED_PICK, 1000);
        apb(1, OFS_SHED_TPU, 20);
        hi = 16'd1500 + ($random(seed) & 16'hFF);
        run_req <= 1'b1;
        demand <= hi;
        repeat (60) @(posedge pclk);
        chk(shed_contact, 0);
        apb(1, OFS_CTRL, 1);
        run_req <= 1'b0;
        repeat (60) @(posedge pclk);
        chk(shed_contact, 0);
        $display("disabled and stopped test done");
        for (int p = 0; p < 2; p++) begin
            tdo = p ? 0 : 10;
            apb(1, OFS_SHED_TDO, tdo);
            apb(1, OFS_SHED_DROP, 700);
            apb(1, OFS_CTRL, {p[0], 1'b1});
            pol <= p[0];
            demand <= 0;
            run_req <= 1'b1;
            repeat (40) @(posedge pclk);
            demand <= hi;
            repeat (10) @(posedge pclk);
            demand <= 0;
            repeat (3) @(posedge pclk);
            demand <= hi;
            meas(!p[0]);
            // Pickup delay of 20 plus load, entry, expiry, state, contact and sampling stages
            chk(n, 26);
            repeat (60) @(posedge pclk);
            chk(shed_contact, !p[0]);
            apb(1, OFS_SHED_DROP, 900);
            meas(p[0]);
            demand <= 0;
            chk(n >= tdo && n <= tdo + 5, 1);
        end
        repeat (40) @(posedge pclk);
        apb(1, OFS_CTRL, 0);
        // Disabling with a polarity change leaves the contact alone; pol stays 1 to match it
        @(posedge pclk);
        chk(shed_contact, 1);
        $display("load shed test done");
        run_req <= 1'b0;
        apb(1, OFS_START_DLY, 8);
        apb(1, OFS_RUN_DLY, 5);
        for (int i = 0; i < 2; i++) begin
            apb(1, OFS_STALL0 + STALL_STRIDE * i + OFS_ST_PICK, 1000 + 200 * i);
            apb(1, OFS_STALL0 + STALL_STRIDE * i + OFS_ST_TMR, 10);
            apb(1, OFS_STALL0 + STALL_STRIDE * i + OFS_ST_MODE, 1 - i);
        end
        apb(1, OFS_IRQ_STAT, 32'h1F);
        run_req <= 1'b1;
        repeat (20) @(posedge pclk);
        demand <= hi;
        repeat (3) @(posedge pclk);
        demand <= 0;
        repeat (15) @(posedge pclk);
        chk(stall_alarm, 0);
        run_req <= 1'b0;
        repeat (6) @(posedge pclk);
        run_req <= 1'b1;
        demand <= hi;
        wait_alarm();
        chk(n >= 14 && n <= 21, 1);
        chk(stall_alarm, 2'b11);
        repeat (20) @(posedge pclk);
        chk(stall_trip, 2'b01);
        apb(0, OFS_STATUS, 0);
        chk(rd, 32'h0E);
        $display("stall test done");
        apb(0, OFS_IRQ_STAT, 0); chk(rd, 32'h0E);
        apb(1, OFS_IRQ_MASK, 0);
        @(posedge pclk);
        s0 = irq;
        apb(1, OFS_IRQ_MASK, 32'h1F);
        @(posedge pclk);
        chk(s0 ^ irq, 1);
        apb(1, OFS_IRQ_STAT, 32'h1F);
        @(posedge pclk);
        chk(irq, 0);
        run_req <= 1'b0;
        demand <= 0;
        repeat (10) @(posedge pclk);
        $display("interrupt test done");
        end_of_test();
    end
endmodule

// ==== mlsg_timer.sv ====
`timescale 1ns/1ps
module mlsg_timer
    import mlsg_pkg::*;
#(
    parameter int W = TMR_W
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         cond,
    input  wire logic [W-1:0] limit,
    output logic              expired
);
    logic [W-1:0] count;

    // Restarts from zero whenever the condition lapses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (!cond) begin
            count <= '0;
        end else if (count < limit) begin
            count <= count + W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expired <= 1'b0;
        end else begin
            expired <= cond && (count >= limit);
        end
    end
endmodule

// ==== mlsg_top.sv ====
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module mlsg_top
    import mlsg_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [CUR_W-1:0]     motor_current,
    input  wire logic                 motor_run,
    output logic                      shed_contact,
    output logic [NUM_STALL-1:0]      stall_alarm,
    output logic [NUM_STALL-1:0]      stall_trip,
    output logic                      irq
);
    import mlsg_pkg::*;

    typedef enum logic [1:0] {
        SHED_IDLE    = 2'b00,
        SHED_PICKING = 2'b01,
        SHED_ACTIVE  = 2'b11,
        SHED_DROPPING = 2'b10
    } mlsg_shed_t;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic                   shed_en;
    logic                   shed_pol;
    logic [CUR_W-1:0]       shed_pick;
    logic [CUR_W-1:0]       shed_drop;
    logic [TMR_W-1:0]       shed_tpu;
    logic [TMR_W-1:0]       shed_tdo;
    logic [TMR_W-1:0]       start_dly;
    logic [TMR_W-1:0]       run_dly;
    logic [IRQ_W-1:0]       irq_stat;
    logic [IRQ_W-1:0]       irq_mask;
    logic [CUR_W-1:0]       st_pick [NUM_STALL];
    logic [TMR_W-1:0]       st_tmr  [NUM_STALL];
    logic [NUM_STALL-1:0]   st_mode;

    logic                   wr_en;
    logic                   rd_en;
    logic                   shed_on;
    logic                   shed_on_d;
    logic [NUM_STALL-1:0]   alarm_w;
    logic [NUM_STALL-1:0]   trip_w;
    logic [NUM_STALL-1:0]   alarm_d;
    logic [NUM_STALL-1:0]   trip_d;
    logic [IRQ_W-1:0]       events;
    logic [31:0]            next_prdata;
    logic                   next_slverr;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shed_en   <= 1'b0;
            shed_pol  <= 1'b0;
            shed_pick <= '1;
            shed_drop <= '0;
            shed_tpu  <= '0;
            shed_tdo  <= '0;
            start_dly <= '0;
            run_dly   <= '0;
            irq_mask  <= '0;
        end else if (wr_en) begin
            if (paddr == OFS_CTRL) begin
                shed_en  <= pwdata[CTRL_SHED_EN];
                shed_pol <= pwdata[CTRL_SHED_POL];
            end else if (paddr == OFS_SHED_PICK) begin
                shed_pick <= pwdata[CUR_W-1:0];
            end else if (paddr == OFS_SHED_DROP) begin
                shed_drop <= pwdata[CUR_W-1:0];
            end else if (paddr == OFS_SHED_TPU) begin
                shed_tpu <= pwdata[TMR_W-1:0];
            end else if (paddr == OFS_SHED_TDO) begin
                shed_tdo <= pwdata[TMR_W-1:0];
            end else if (paddr == OFS_START_DLY) begin
                start_dly <= pwdata[TMR_W-1:0];
            end else if (paddr == OFS_RUN_DLY) begin
                run_dly <= pwdata[TMR_W-1:0];
            end else if (paddr == OFS_IRQ_MASK) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Per-element settings, each independent
    genvar gi;
    generate
        for (gi = 0; gi < NUM_STALL; gi++) begin : g_stcfg
            localparam logic [11:0] BASE = 12'(OFS_STALL0 + STALL_STRIDE * gi);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st_pick[gi] <= '1;
                    st_tmr[gi]  <= '0;
                    st_mode[gi] <= 1'b0;
                end else if (wr_en) begin
                    if (paddr == BASE + OFS_ST_PICK) begin
                        st_pick[gi] <= pwdata[CUR_W-1:0];
                    end else if (paddr == BASE + OFS_ST_TMR) begin
                        st_tmr[gi] <= pwdata[TMR_W-1:0];
                    end else if (paddr == BASE + OFS_ST_MODE) begin
                        st_mode[gi] <= pwdata[0];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read path, zero wait states; reads of unmapped addresses error
    always_comb begin
        next_prdata = RST_ZERO;
        next_slverr = 1'b0;
        if (paddr == OFS_CTRL) begin
            next_prdata[CTRL_SHED_EN]  = shed_en;
            next_prdata[CTRL_SHED_POL] = shed_pol;
        end else if (paddr == OFS_SHED_PICK) begin
            next_prdata[CUR_W-1:0] = shed_pick;
        end else if (paddr == OFS_SHED_DROP) begin
            next_prdata[CUR_W-1:0] = shed_drop;
        end else if (paddr == OFS_SHED_TPU) begin
            next_prdata[TMR_W-1:0] = shed_tpu;
        end else if (paddr == OFS_SHED_TDO) begin
            next_prdata[TMR_W-1:0] = shed_tdo;
        end else if (paddr == OFS_START_DLY) begin
            next_prdata[TMR_W-1:0] = start_dly;
        end else if (paddr == OFS_RUN_DLY) begin
            next_prdata[TMR_W-1:0] = run_dly;
        end else if (paddr == OFS_STATUS) begin
            next_prdata[ST_SHED] = shed_on;
            next_prdata[ST_ALARM0 +: NUM_STALL] = alarm_w;
            next_prdata[ST_TRIP0 +: NUM_STALL]  = trip_w;
        end else if (paddr == OFS_IRQ_STAT) begin
            next_prdata[IRQ_W-1:0] = irq_stat;
        end else if (paddr == OFS_IRQ_MASK) begin
            next_prdata[IRQ_W-1:0] = irq_mask;
        end else if (paddr == OFS_STALL0 + OFS_ST_PICK) begin
            next_prdata[CUR_W-1:0] = st_pick[0];
        end else if (paddr == OFS_STALL0 + OFS_ST_TMR) begin
            next_prdata[TMR_W-1:0] = st_tmr[0];
        end else if (paddr == OFS_STALL0 + OFS_ST_MODE) begin
            next_prdata[0] = st_mode[0];
        end else if (paddr == OFS_STALL0 + STALL_STRIDE + OFS_ST_PICK) begin
            next_prdata[CUR_W-1:0] = st_pick[1];
        end else if (paddr == OFS_STALL0 + STALL_STRIDE + OFS_ST_TMR) begin
            next_prdata[TMR_W-1:0] = st_tmr[1];
        end else if (paddr == OFS_STALL0 + STALL_STRIDE + OFS_ST_MODE) begin
            next_prdata[0] = st_mode[1];
        end else begin
            next_slverr = 1'b1;
        end
    end

    // pready rises on the first access cycle, so every transfer is zero-wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= RST_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && next_slverr;
            if (psel && !penable && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Load shedding
    mlsg_shed_t shed_state;
    logic       shed_run;
    logic       above_pick;
    logic       below_drop;
    logic       pu_done;
    logic       do_done;

    assign shed_run   = shed_en && motor_run;
    assign above_pick = motor_current > shed_pick;
    assign below_drop = motor_current < shed_drop;

    mlsg_timer #(.W(TMR_W)) u_shed_pu (
        .pclk    (pclk),
        .presetn (presetn),
        .cond    (shed_run && above_pick && shed_state == SHED_PICKING),
        .limit   (shed_tpu),
        .expired (pu_done)
    );

    mlsg_timer #(.W(TMR_W)) u_shed_do (
        .pclk    (pclk),
        .presetn (presetn),
        .cond    (shed_run && below_drop && shed_state == SHED_DROPPING),
        .limit   (shed_tdo),
        .expired (do_done)
    );

    // Disable freezes the contact where it is rather than releasing it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shed_state <= SHED_IDLE;
        end else if (shed_run) begin
            case (shed_state)
                SHED_IDLE: begin
                    if (above_pick) shed_state <= SHED_PICKING;
                end
                SHED_PICKING: begin
                    if (!above_pick) shed_state <= SHED_IDLE;
                    else if (pu_done) shed_state <= SHED_ACTIVE;
                end
                SHED_ACTIVE: begin
                    if (below_drop) shed_state <= SHED_DROPPING;
                end
                SHED_DROPPING: begin
                    if (!below_drop) shed_state <= SHED_ACTIVE;
                    else if (do_done) shed_state <= SHED_IDLE;
                end
                default: shed_state <= SHED_IDLE;
            endcase
        end
    end

    assign shed_on = (shed_state == SHED_ACTIVE) || (shed_state == SHED_DROPPING);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shed_contact <= 1'b0;
        end else if (shed_en) begin
            // Held while disabled, even when a write flips the polarity
            shed_contact <= shed_on ^ shed_pol;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stall elements
    logic start_done;

    // Start delay counts from run onset; stall logic is blind until then
    mlsg_timer #(.W(TMR_W)) u_start (
        .pclk    (pclk),
        .presetn (presetn),
        .cond    (motor_run),
        .limit   (start_dly),
        .expired (start_done)
    );

    generate
        for (gi = 0; gi < NUM_STALL; gi++) begin : g_stall
            mlsg_stall u_stall (
                .pclk        (pclk),
                .presetn     (presetn),
                .enable      (motor_run && start_done),
                .current     (motor_current),
                .pickup      (st_pick[gi]),
                .run_delay   (run_dly),
                .trip_delay  (st_tmr[gi]),
                .trip_active (st_mode[gi]),
                .alarm       (alarm_w[gi]),
                .trip        (trip_w[gi])
            );
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_alarm <= '0;
            stall_trip  <= '0;
        end else begin
            stall_alarm <= alarm_w;
            stall_trip  <= trip_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts on rising edges; set beats write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shed_on_d <= 1'b0;
            alarm_d   <= '0;
            trip_d    <= '0;
        end else begin
            shed_on_d <= shed_on;
            alarm_d   <= alarm_w;
            trip_d    <= trip_w;
        end
    end

    assign events = {trip_w & ~trip_d, alarm_w & ~alarm_d, shed_on & ~shed_on_d};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else if (wr_en && paddr == OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | events;
        end else begin
            irq_stat <= irq_stat | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end
endmodule
